//--- hw/mlu_pkg.sv
// Purpose: shared types and constants of the memory load unit
// Assumes: one core clock; memory returns the addressed bytes right-justified
// Notes:   register numbers 0..15 are the local bank, 16..31 the global bank
//
// Operation
// RL1: fetch bytes at address, write destination registers
// RL2: any addressing mode; address arrives already computed
// RL3: destination is single or lowest of group
// RL4: byte and half-word loads widen to 32 bits
// RL5: word/long/triple/quad move 4/8/12/16 bytes
// RL6: software gives even register for long load
// RL7: software gives multiple-of-four for triple/quad
// RL8: software keeps multi-word within one bank
// RL9: ordinal zero-fills, integer sign-extends when widening
// RL10: lowest address word goes to lowest register
package mlu_pkg;

  // ----------------------------------------------------------------
  // load kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MLU_LOAD_WORD      = 3'h0,
    MLU_LOAD_ORD_BYTE  = 3'h1,
    MLU_LOAD_ORD_SHORT = 3'h2,
    MLU_LOAD_INT_BYTE  = 3'h3,
    MLU_LOAD_INT_SHORT = 3'h4,
    MLU_LOAD_LONG      = 3'h5,
    MLU_LOAD_TRIPLE    = 3'h6,
    MLU_LOAD_QUAD      = 3'h7
  } mlu_kind_t;

  // ----------------------------------------------------------------
  // memory access size codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MLU_SIZE_BYTE = 2'h0,
    MLU_SIZE_HALF = 2'h1,
    MLU_SIZE_WORD = 2'h2
  } mlu_size_t;

  // ----------------------------------------------------------------
  // widths and steps
  // ----------------------------------------------------------------
  localparam int unsigned    DATA_W      = 32;
  localparam int unsigned    ADDR_W      = 32;
  localparam int unsigned    REG_NUM_W   = 5;
  localparam int unsigned    BYTE_W      = 8;
  localparam int unsigned    HALF_W      = 16;
  localparam int unsigned    CNT_W       = 2;
  localparam logic [31:0]    WORD_STEP   = 32'h0000_0004;
  localparam logic [2:0]     WORDS_ONE   = 3'h1;
  localparam logic [2:0]     WORDS_LONG  = 3'h2;
  localparam logic [2:0]     WORDS_TRIP  = 3'h3;
  localparam logic [2:0]     WORDS_QUAD  = 3'h4;
  localparam logic [1:0]     CNT_ZERO    = 2'h0;
  localparam logic [1:0]     CNT_ONE     = 2'h1;
  localparam logic [3:0]     IDX_ONE     = 4'h1;

endpackage

//--- hw/mlu_load_unit.sv
// Purpose: executes the memory-to-register load family
// Assumes: this unit holds mem_req until mem_ack, data valid with mem_ack,
//          addressed bytes right-justified on mem_rdata; same clock
// Notes:   one register write per fetched word; start ignored while busy
`timescale 1ns/100ps
`default_nettype none

module mlu_load_unit (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          start,
  input  wire mlu_pkg::mlu_kind_t            kind,
  input  wire logic [mlu_pkg::ADDR_W-1:0]    eff_addr,
  input  wire logic [mlu_pkg::REG_NUM_W-1:0] dst_reg,
  output logic                               busy_r,
  output logic                               done_r,
  output logic                               mem_req_r,
  output logic [mlu_pkg::ADDR_W-1:0]         mem_addr_r,
  output mlu_pkg::mlu_size_t                 mem_size_r,
  input  wire logic                          mem_ack,
  input  wire logic [mlu_pkg::DATA_W-1:0]    mem_rdata,
  output logic                               reg_we_r,
  output logic [mlu_pkg::REG_NUM_W-1:0]      reg_num_r,
  output logic [mlu_pkg::DATA_W-1:0]         reg_wdata_r
);
  import mlu_pkg::*;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MLU_IDLE  = 3'b001,
    MLU_FETCH = 3'b010,
    MLU_WRITE = 3'b100
  } mlu_state_t;

  mlu_state_t                state_r, state_nxt;
  mlu_kind_t                 kind_r, kind_nxt;
  logic [CNT_W-1:0]          idx_r, idx_nxt;
  logic [CNT_W-1:0]          last_r, last_nxt;
  logic [DATA_W-1:0]         data_r, data_nxt;
  logic                      busy_nxt;
  logic                      done_nxt;
  logic                      mem_req_nxt;
  logic [ADDR_W-1:0]         mem_addr_nxt;
  mlu_size_t                 mem_size_nxt;
  logic                      reg_we_nxt;
  logic [REG_NUM_W-1:0]      reg_num_nxt;
  logic [DATA_W-1:0]         reg_wdata_nxt;
  logic [REG_NUM_W-1:0]      base_r, base_nxt;
  logic [2:0]                words;
  logic [DATA_W-1:0]         widened;

  // ----------------------------------------------------------------
  // word count and widening
  // ----------------------------------------------------------------
  always_comb begin
    unique case (kind)
      MLU_LOAD_LONG:   words = WORDS_LONG;   // [RL5]
      MLU_LOAD_TRIPLE: words = WORDS_TRIP;   // [RL5]
      MLU_LOAD_QUAD:   words = WORDS_QUAD;   // [RL5]
      default:         words = WORDS_ONE;    // [RL5]
    endcase
  end

  always_comb begin
    unique case (kind_r)
      MLU_LOAD_ORD_BYTE:  widened = {{(DATA_W-BYTE_W){1'b0}}, mem_rdata[BYTE_W-1:0]};  // [RL4] [RL9]
      MLU_LOAD_ORD_SHORT: widened = {{(DATA_W-HALF_W){1'b0}}, mem_rdata[HALF_W-1:0]};  // [RL4] [RL9]
      MLU_LOAD_INT_BYTE:  widened = {{(DATA_W-BYTE_W){mem_rdata[BYTE_W-1]}},
                                     mem_rdata[BYTE_W-1:0]};                              // [RL4] [RL9]
      MLU_LOAD_INT_SHORT: widened = {{(DATA_W-HALF_W){mem_rdata[HALF_W-1]}},
                                     mem_rdata[HALF_W-1:0]};                              // [RL4] [RL9]
      default:            widened = mem_rdata;
    endcase
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    kind_nxt      = kind_r;
    idx_nxt       = idx_r;
    last_nxt      = last_r;
    data_nxt      = data_r;
    base_nxt      = base_r;
    busy_nxt      = busy_r;
    done_nxt      = 1'b0;
    mem_req_nxt   = mem_req_r;
    mem_addr_nxt  = mem_addr_r;
    mem_size_nxt  = mem_size_r;
    reg_we_nxt    = 1'b0;
    reg_num_nxt   = reg_num_r;
    reg_wdata_nxt = reg_wdata_r;
    unique case (state_r)
      MLU_IDLE: begin
        if (start) begin
          // the address is taken as computed, whatever mode produced it
          state_nxt    = MLU_FETCH;
          kind_nxt     = kind;
          idx_nxt      = CNT_ZERO;
          last_nxt     = CNT_W'(words - WORDS_ONE);
          base_nxt     = dst_reg;                   // [RL3]
          busy_nxt     = 1'b1;
          mem_req_nxt  = 1'b1;                      // [RL1]
          mem_addr_nxt = eff_addr;                  // [RL2]
          unique case (kind)
            MLU_LOAD_ORD_BYTE, MLU_LOAD_INT_BYTE:   mem_size_nxt = MLU_SIZE_BYTE;
            MLU_LOAD_ORD_SHORT, MLU_LOAD_INT_SHORT: mem_size_nxt = MLU_SIZE_HALF;
            default:                                mem_size_nxt = MLU_SIZE_WORD;
          endcase
        end
      end
      MLU_FETCH: begin
        if (mem_ack) begin
          state_nxt   = MLU_WRITE;
          mem_req_nxt = 1'b0;
          data_nxt    = widened;
        end
      end
      MLU_WRITE: begin
        // the bank bit is kept; a group running off the bank end wraps, its result undefined
        reg_we_nxt    = 1'b1;                                                   // [RL1]
        reg_num_nxt   = {base_r[REG_NUM_W-1], base_r[REG_NUM_W-2:0] +
                         {{(REG_NUM_W-1-CNT_W){1'b0}}, idx_r}};                 // [RL10] [RL8]
        reg_wdata_nxt = data_r;
        if (idx_r == last_r) begin
          state_nxt = MLU_IDLE;
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
        end else begin
          state_nxt    = MLU_FETCH;
          idx_nxt      = idx_r + CNT_ONE;
          mem_req_nxt  = 1'b1;
          mem_addr_nxt = mem_addr_r + WORD_STEP;                               // [RL10]
        end
      end
      default: begin
        state_nxt   = MLU_IDLE;
        busy_nxt    = 1'b0;
        mem_req_nxt = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r     <= MLU_IDLE;
      kind_r      <= MLU_LOAD_WORD;
      idx_r       <= CNT_ZERO;
      last_r      <= CNT_ZERO;
      data_r      <= '0;
      base_r      <= '0;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      mem_req_r   <= 1'b0;
      mem_addr_r  <= '0;
      mem_size_r  <= MLU_SIZE_WORD;
      reg_we_r    <= 1'b0;
      reg_num_r   <= '0;
      reg_wdata_r <= '0;
    end else begin
      state_r     <= state_nxt;
      kind_r      <= kind_nxt;
      idx_r       <= idx_nxt;
      last_r      <= last_nxt;
      data_r      <= data_nxt;
      base_r      <= base_nxt;
      busy_r      <= busy_nxt;
      done_r      <= done_nxt;
      mem_req_r   <= mem_req_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_size_r  <= mem_size_nxt;
      reg_we_r    <= reg_we_nxt;
      reg_num_r   <= reg_num_nxt;
      reg_wdata_r <= reg_wdata_nxt;
    end
  end

endmodule

`default_nettype wire

//--- dv/mlu_load_chk.sv
// Purpose: port checker for the load unit
// Assumes: one clock, asynchronous active-high reset
// Notes:   keeps the kind of the load in flight
`timescale 1ns/100ps
`default_nettype none
module mlu_load_chk
  import mlu_pkg::*;
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               start,
  input wire mlu_pkg::mlu_kind_t kind,
  input wire logic [31:0]        eff_addr,
  input wire logic               busy_r,
  input wire logic               mem_req_r,
  input wire logic [31:0]        mem_addr_r,
  input wire logic               mem_ack,
  input wire logic [31:0]        mem_rdata,
  input wire logic               reg_we_r,
  input wire logic [31:0]        reg_wdata_r
);
  mlu_kind_t kind_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a start seen while busy must not disturb the kind in flight
  always_ff @(posedge clk or posedge reset)
    if (reset) kind_r <= MLU_LOAD_WORD;
    else if (start && !busy_r) kind_r <= kind;
  start_req_a: assert property (start && !busy_r |=> mem_req_r && mem_addr_r == $past(eff_addr))
    else $error("no fetch at start");
  req_hold_a: assert property (mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r))
    else $error("request dropped");
  ack_write_a: assert property (mem_req_r && mem_ack |=> !mem_req_r ##1 reg_we_r)
    else $error("no write after answer");
  next_addr_a: assert property (reg_we_r && mem_req_r |-> mem_addr_r == $past(mem_addr_r, 2) + WORD_STEP)
    else $error("next word address");
  zero_fill_a: assert property (
    reg_we_r && kind_r == MLU_LOAD_ORD_SHORT |-> reg_wdata_r == {16'h0, $past(mem_rdata[15:0], 2)})
    else $error("zero fill");
  sign_fill_a: assert property (
    reg_we_r && kind_r == MLU_LOAD_INT_BYTE |-> reg_wdata_r == {{24{$past(mem_rdata[7], 2)}}, $past(mem_rdata[7:0], 2)})
    else $error("sign fill");
  word_data_a: assert property (reg_we_r && kind_r == MLU_LOAD_QUAD |-> reg_wdata_r == $past(mem_rdata, 2))
    else $error("word data");
endmodule
`default_nettype wire

//--- dv/mlu_mem_model.sv
// Purpose: memory behind the fetch port
// Assumes: request held until answered
// Notes:   slow adds three wait cycles; answer is the inverted address
`timescale 1ns/100ps
`default_nettype none
module mlu_mem_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        mem_req_r,
  input  wire logic [31:0] mem_addr_r,
  output var  logic        mem_ack,
  output wire logic [31:0] mem_rdata
);
  logic [1:0] wait_r;
  // off-answer the bus shows other bits, so a stale capture cannot pass
  assign mem_rdata = mem_ack ? ~mem_addr_r : mem_addr_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_ack <= 1'b0;
      wait_r  <= 2'h0;
    end else if (mem_ack || !mem_req_r) begin
      mem_ack <= 1'b0;
      wait_r  <= 2'h0;
    end else if (!slow || wait_r == 2'h3)
      mem_ack <= 1'b1;
    else
      wait_r <= wait_r + 2'h1;
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for the load unit
// Assumes: memory answers with the inverted address
// Notes:   every start is held one extra edge, which must be ignored
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mlu_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, start = 1'b0, slow = 1'b0;
  mlu_kind_t   kind = MLU_LOAD_WORD;
  logic [31:0] eff_addr = 32'h0;
  logic [4:0]  dst_reg = 5'h0;
  logic        busy_r, done_r, mem_req_r, mem_ack, reg_we_r;
  logic [31:0] mem_addr_r, mem_rdata, reg_wdata_r;
  logic [4:0]  reg_num_r;
  mlu_size_t   mem_size_r;
  int          error_cnt = 0, n_tests = 0;
  always #4 clk = ~clk;
  mlu_load_unit u_dut (.clk, .reset, .start, .kind, .eff_addr, .dst_reg, .busy_r, .done_r, .mem_req_r,
    .mem_addr_r, .mem_size_r, .mem_ack, .mem_rdata, .reg_we_r, .reg_num_r, .reg_wdata_r);
  mlu_mem_model u_mem (.clk, .reset, .slow, .mem_req_r, .mem_addr_r, .mem_ack, .mem_rdata);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_load(mlu_kind_t k, logic [31:0] ea, logic [4:0] d);
    logic [31:0] e;
    int          i;
    mlu_size_t   sz;
    i = 0;
    case (k)
      MLU_LOAD_ORD_BYTE, MLU_LOAD_INT_BYTE:   sz = MLU_SIZE_BYTE;
      MLU_LOAD_ORD_SHORT, MLU_LOAD_INT_SHORT: sz = MLU_SIZE_HALF;
      default:                                sz = MLU_SIZE_WORD;
    endcase
    kind = k;
    eff_addr = ea;
    dst_reg = d;
    start = 1'b1;
    for (int t = 0; t < 80 && done_r !== 1'b1; t++) begin
      @(negedge clk);
      if (t == 1) start = 1'b0;
      if (mem_req_r === 1'b1) begin
        check("mem_size_r", {30'h0, sz}, {30'h0, mem_size_r});
      end
      if (reg_we_r === 1'b1) begin
        case (k)
          MLU_LOAD_ORD_BYTE:  e = {24'h0, ~ea[7:0]};
          MLU_LOAD_INT_BYTE:  e = {{24{~ea[7]}}, ~ea[7:0]};
          MLU_LOAD_ORD_SHORT: e = {16'h0, ~ea[15:0]};
          MLU_LOAD_INT_SHORT: e = {{16{~ea[15]}}, ~ea[15:0]};
          default:            e = ~(ea + {i[29:0], 2'h0});
        endcase
        check("reg_wdata_r", e, reg_wdata_r);
        check("reg_num_r", {d[4], d[3:0] + i[3:0]}, reg_num_r);
        i++;
      end
    end
    if (done_r !== 1'b1) begin
      check("done_r", 32'h1, {31'h0, done_r});
      complete_run();
    end
    check("writes", (k == MLU_LOAD_LONG) ? 2 : (k == MLU_LOAD_TRIPLE) ? 3 : (k == MLU_LOAD_QUAD) ? 4 : 1, i);
    check("busy_r", 32'h0, {31'h0, busy_r});
    @(negedge clk);
  endtask
  task automatic t_widen();
    for (int k = 1; k < 5; k++) begin
      do_load(mlu_kind_t'(k), 32'h1000_0100, 5'h3);
      do_load(mlu_kind_t'(k), 32'h0000_8080, 5'h13);
    end
  endtask
  task automatic t_multi();
    do_load(MLU_LOAD_WORD, 32'h0000_0203, 5'h1);
    do_load(MLU_LOAD_LONG, 32'h0000_2456, 5'hA);
    do_load(MLU_LOAD_TRIPLE, 32'h0000_3000, 5'h4);
    do_load(MLU_LOAD_QUAD, 32'h8000_0FF0, 5'h8);
  endtask
  task automatic t_slow();
    slow = 1'b1;
    do_load(MLU_LOAD_QUAD, 32'h0001_0010, 5'h14);
    do_load(MLU_LOAD_ORD_SHORT, 32'h0000_0102, 5'h1F);
    slow = 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_widen();
    t_multi();
    t_slow();
    complete_run();
  end
endmodule
bind mlu_load_unit mlu_load_chk u_chk (.clk, .reset, .start, .kind, .eff_addr, .busy_r, .mem_req_r,
  .mem_addr_r, .mem_ack, .mem_rdata, .reg_we_r, .reg_wdata_r);
`default_nettype wire
